// ### ddcns_consts.svh
// Register map, field positions, reset values and fixed sizes of the down-converter core
`ifndef DDCNS_CONSTS_SVH
`define DDCNS_CONSTS_SVH
`define DDCNS_OFS_CTRL 12'h000
`define DDCNS_OFS_RDIV 12'h004
`define DDCNS_OFS_STATUS 12'h008
`define DDCNS_OFS_FREQ_BASE 12'h020
`define DDCNS_OFS_PHASE_BASE 12'h040
`define DDCNS_CTRL_LINK_EN 0
`define DDCNS_CTRL_SYNC_INIT 1
`define DDCNS_CTRL_SYNC_ARM 2
`define DDCNS_CTRL_ENC64 3
`define DDCNS_CTRL_DEC_LSB 4
`define DDCNS_CTRL_SEL_A_LSB 8
`define DDCNS_CTRL_SEL_B_LSB 10
`define DDCNS_RST_FREQ 32'h0000_0000
`define DDCNS_RST_PHASE 16'h0000
`define DDCNS_RST_RDIV 16'h0000
`define DDCNS_RST_DEC 3'h0
`define DDCNS_RDIV_SHIFT 26
`define DDCNS_RDIV_ROUND 49'h0_0000_0200_0000
`define DDCNS_PHASE_STEP 64
`define DDCNS_NUM_STAGES 5
`define DDCNS_DATA_W 15
`define DDCNS_MIX_SHIFT 11
`endif

// ### ddcns_core.sv
// Oscillator bank, sync control, mixer and halving-stage decimator with APB registers
// Behaviour
// [RULE1] Divider zero: oscillator advances by the 32-bit word each sample, sign-agnostic.
// [RULE2] Divider nonzero: accumulator lands exactly on multiples of clock/(64*divider).
// [RULE3] Software picks divider as clock/step/64, an integer.
// [RULE4] Software keeps the divider at or below 8192.
// [RULE5] Software sets the word to round(2^26*N/divider).
// [RULE6] Software picks the divider matching its real sample clock.
// [RULE7] Each of eight 16-bit phase words is added at the accumulator's top bits.
// [RULE8] Software resynchronizes oscillators after changing any frequency word.
// [RULE9] Resync comes from link init or SYSREF, chosen by enable and arm bits.
// [RULE10] Link-sync resync also works in 64b/66b encoding modes.
// [RULE11] Link-init order: enable sync, link off, program, sync high, link on.
// [RULE12] Sync driven low starts code group sync or arms the trigger.
// [RULE13] Oscillators reset on the rising sync release from the receiver.
// [RULE14] DC SYSREF: link on, program, arm with SYSREF low, then one pulse.
// [RULE15] Armed device resets all oscillators on the next SYSREF rising edge.
// [RULE16] AC SYSREF: arming write ends between two SYSREF rising edges.
// [RULE17] Arm stays pending until an edge consumes it; one reset per arming.
// [RULE18] Bypass outputs real 12-bit samples every clock, unfiltered.
// [RULE19] Filters take complex mixer output, give 15-bit complex results.
// [RULE20] Filters are linear-phase FIR.
// [RULE21] Factor D gives output rate clock/D.
// [RULE22] Factors 4..32 use the last two..all five halving stages.
// [RULE23] Each stage uses symmetric taps around one centre tap, sharing multipliers.
// [RULE24] Output words carry 15-bit complex data plus two overrange flags.
//
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "ddcns_consts.svh"
module ddcns_core #(
  parameter int SAMPLE_W = 12
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire ddcns_pkg::ddcns_apb_req_t apb_req_i,
  output ddcns_pkg::ddcns_apb_rsp_t apb_rsp_o,
  input wire logic link_sync_n_i,
  input wire logic sysref_i,
  input wire logic [1:0][SAMPLE_W-1:0] sample_i,
  input wire logic [1:0][1:0] ovr_i,
  output logic serial_link_enable_o,
  output logic nco_sync_o,
  output ddcns_pkg::ddcns_word_t [1:0] ddc_out_o
);
  import ddcns_pkg::*;

  localparam int DW = `DDCNS_DATA_W;
  localparam int NS = `DDCNS_NUM_STAGES;

  // The mixer output must fit the 15-bit data path with headroom for the LUT gain
  if (SAMPLE_W < 8 || SAMPLE_W > 13) begin : g_bad_width
    $error("SAMPLE_W must lie between 8 and 13");
  end

  // Stage s runs for modes 4-s..4 and never below mode 1; the last two stages are shared by all factors
  function automatic logic stage_used(input logic [2:0] mode, input int s);
    stage_used = (mode >= 3'h1) && (mode <= 3'h4) && (s >= 4 - int'(mode));
  endfunction

  // Cosine over 32 phase steps, folded from a nine-entry quarter wave
  function automatic logic signed [11:0] cos_lut(input logic [4:0] p);
    logic [3:0] k;
    logic [11:0] m;
    k = p[3] ? 4'(5'd16 - {2'b00, p[2:0]} - 5'd8) : {1'b0, p[2:0]};
    case (k)
      4'h0: m = 12'h7FF;
      4'h1: m = 12'h7D8;
      4'h2: m = 12'h763;
      4'h3: m = 12'h6A6;
      4'h4: m = 12'h5A7;
      4'h5: m = 12'h471;
      4'h6: m = 12'h30F;
      4'h7: m = 12'h18F;
      default: m = 12'h000;
    endcase
    cos_lut = (p[4] ^ p[3]) ? -$signed(m) : $signed(m);
  endfunction

  // Half-band taps -1 0 9 16 9 0 -1 over 32; mirrored pairs share one multiply
  function automatic logic signed [DW-1:0] hb_fir(input logic signed [DW-1:0] x0, x2, x3,
                                                   x4, x6);
    logic signed [DW+6:0] acc;
    acc = 22'sd9 * (22'(x2) + 22'(x4)) + 22'sd16 * 22'(x3) - (22'(x0) + 22'(x6));
    acc = acc >>> 5;
    if (acc > 22'sd16383) hb_fir = 15'sh3FFF;
    else if (acc < -22'sd16384) hb_fir = 15'sh4000;
    else hb_fir = acc[DW-1:0];
  endfunction

  // APB slave: one wait state so read data and answer come from flip-flops
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic link_en_reg;
  logic sync_init_en_reg;
  logic enc64_reg;
  logic arm_reg;
  logic [2:0] dec_mode_reg;
  logic [1:0] sel_a_reg;
  logic [1:0] sel_b_reg;
  logic [15:0] rational_step_divider_reg;
  logic [31:0] osc_freq_word_path_a_reg [0:3];
  logic [31:0] osc_freq_word_path_b_reg [0:3];
  logic [15:0] osc_phase_word_path_a_reg [0:3];
  logic [15:0] osc_phase_word_path_b_reg [0:3];
  logic [7:0] sync_count_reg;
  logic nco_sync_reg;
  ddcns_link_state_t ls_reg;
  ddcns_link_state_t ls_next;

  wire apb_access = apb_req_i.psel & apb_req_i.penable;
  wire apb_wr = apb_access & pready_reg & apb_req_i.pwrite;
  wire [11:0] addr = apb_req_i.paddr;
  wire [31:0] wd = apb_req_i.pwdata;
  wire [2:0] idx = addr[4:2];
  wire hit_ctrl = addr == `DDCNS_OFS_CTRL;
  wire hit_rdiv = addr == `DDCNS_OFS_RDIV;
  wire hit_status = addr == `DDCNS_OFS_STATUS;
  wire hit_freq = addr[11:5] == `DDCNS_OFS_FREQ_BASE >> 5 && addr[1:0] == 2'b00;
  wire hit_phase = addr[11:5] == `DDCNS_OFS_PHASE_BASE >> 5 && addr[1:0] == 2'b00;
  wire addr_ok = hit_ctrl | hit_rdiv | hit_status | hit_freq | hit_phase;
  wire [31:0] ctrl_rd = {20'h0, sel_b_reg, sel_a_reg, 1'b0, dec_mode_reg, enc64_reg, arm_reg,
                         sync_init_en_reg, link_en_reg};
  wire [31:0] status_rd = {16'h0, sync_count_reg, 5'h0, ls_reg};
  wire [31:0] freq_rd = idx[2] ? osc_freq_word_path_b_reg[idx[1:0]] :
                        osc_freq_word_path_a_reg[idx[1:0]];
  wire [15:0] phase_rd = idx[2] ? osc_phase_word_path_b_reg[idx[1:0]] :
                         osc_phase_word_path_a_reg[idx[1:0]];
  wire [31:0] rd_mux = hit_ctrl ? ctrl_rd :
                       hit_rdiv ? {16'h0, rational_step_divider_reg} :
                       hit_status ? status_rd :
                       hit_freq ? freq_rd :
                       hit_phase ? {16'h0, phase_rd} : 32'h0;
  wire pready_next = apb_access & ~pready_reg;

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0;
    end else begin
      pready_reg <= pready_next;
      pslverr_reg <= pready_next & ~addr_ok;
      prdata_reg <= pready_next & ~apb_req_i.pwrite ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      link_en_reg <= 1'b0;
      sync_init_en_reg <= 1'b0;
      enc64_reg <= 1'b0;
      dec_mode_reg <= `DDCNS_RST_DEC;
      sel_a_reg <= 2'h0;
      sel_b_reg <= 2'h0;
      rational_step_divider_reg <= `DDCNS_RST_RDIV;
    end else if (apb_wr && hit_ctrl) begin
      link_en_reg <= wd[`DDCNS_CTRL_LINK_EN];
      sync_init_en_reg <= wd[`DDCNS_CTRL_SYNC_INIT];
      enc64_reg <= wd[`DDCNS_CTRL_ENC64];
      dec_mode_reg <= wd[`DDCNS_CTRL_DEC_LSB +: 3];
      sel_a_reg <= wd[`DDCNS_CTRL_SEL_A_LSB +: 2];
      sel_b_reg <= wd[`DDCNS_CTRL_SEL_B_LSB +: 2];
    end else if (apb_wr && hit_rdiv) begin
      rational_step_divider_reg <= wd[15:0];
    end
  end

  genvar w;
  for (w = 0; w < 4; w++) begin : g_word
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
        osc_freq_word_path_a_reg[w] <= `DDCNS_RST_FREQ;
        osc_freq_word_path_b_reg[w] <= `DDCNS_RST_FREQ;
        osc_phase_word_path_a_reg[w] <= `DDCNS_RST_PHASE;
        osc_phase_word_path_b_reg[w] <= `DDCNS_RST_PHASE;
      end else if (apb_wr && idx[1:0] == 2'(w)) begin
        if (hit_freq && !idx[2]) osc_freq_word_path_a_reg[w] <= wd;
        if (hit_freq && idx[2]) osc_freq_word_path_b_reg[w] <= wd;
        if (hit_phase && !idx[2]) osc_phase_word_path_a_reg[w] <= wd[15:0];
        if (hit_phase && idx[2]) osc_phase_word_path_b_reg[w] <= wd[15:0];
      end
    end
  end

  // Pin inputs: three stages; a level counts only once stages two and three agree
  logic [1:0] sy1_reg;
  logic [1:0] sy2_reg;
  logic [1:0] sy3_reg;
  logic [1:0] lvl_reg;
  logic [1:0] prev_reg;
  wire [1:0] lvl_next = (sy2_reg & sy3_reg) | (lvl_reg & (sy2_reg | sy3_reg));
  wire sysref_rise = lvl_reg[1] & ~prev_reg[1];
  wire link_sync_high = lvl_reg[0];

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sy1_reg <= 2'b01;
      sy2_reg <= 2'b01;
      sy3_reg <= 2'b01;
      lvl_reg <= 2'b01;
      prev_reg <= 2'b01;
    end else begin
      sy1_reg <= {sysref_i, link_sync_n_i};
      sy2_reg <= sy1_reg;
      sy3_reg <= sy2_reg;
      lvl_reg <= lvl_next;
      prev_reg <= lvl_reg;
    end
  end

  // Link-init sync; the same path serves 8b/10b and 64b/66b since only the sync pin counts
  wire link_active = sync_init_en_reg & link_en_reg; // [RULE9] [RULE11]
  wire link_fire = ls_reg == DDCNS_LS_ARMED && link_active && link_sync_high; // [RULE13] [RULE10]
  wire sysref_fire = arm_reg & sysref_rise; // [RULE15]
  wire sync_pulse = link_fire | sysref_fire; // [RULE9]
  // A write that arms in the edge's own cycle survives, so no arming is lost
  wire arm_set = apb_wr & hit_ctrl & wd[`DDCNS_CTRL_SYNC_ARM];
  wire arm_next = arm_set | (arm_reg & ~sysref_rise); // [RULE17]

  always_comb begin
    ls_next = ls_reg;
    case (ls_reg)
      DDCNS_LS_IDLE: if (link_active) ls_next = DDCNS_LS_WAIT;
      DDCNS_LS_WAIT: if (!link_sync_high) ls_next = DDCNS_LS_ARMED; // [RULE12]
      DDCNS_LS_ARMED: if (link_sync_high) ls_next = DDCNS_LS_WAIT; // [RULE13]
      default: ls_next = DDCNS_LS_IDLE;
    endcase
    if (!link_active) ls_next = DDCNS_LS_IDLE;
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ls_reg <= DDCNS_LS_IDLE;
      arm_reg <= 1'b0;
      nco_sync_reg <= 1'b0;
      sync_count_reg <= 8'h0;
    end else begin
      ls_reg <= ls_next;
      arm_reg <= arm_next;
      nco_sync_reg <= sync_pulse;
      sync_count_reg <= sync_count_reg + 8'(sync_pulse);
    end
  end

  // Eight oscillators; a residue counter removes the rounding error of the word
  wire rational = rational_step_divider_reg != 16'h0;
  wire signed [17:0] rdiv_s = {2'b00, rational_step_divider_reg};
  wire [31:0] osc_phase_w [0:7];

  genvar o;
  for (o = 0; o < 8; o++) begin : g_osc
    logic [31:0] acc_reg;
    logic signed [17:0] res_reg;
    wire [31:0] fw = o < 4 ? osc_freq_word_path_a_reg[o % 4] : osc_freq_word_path_b_reg[o % 4];
    wire [15:0] pw = o < 4 ? osc_phase_word_path_a_reg[o % 4] : osc_phase_word_path_b_reg[o % 4];
    wire [48:0] prod = 49'(fw * rational_step_divider_reg) + `DDCNS_RDIV_ROUND;
    wire [21:0] n_steps = prod[`DDCNS_RDIV_SHIFT +: 22];
    wire signed [48:0] r_full = $signed({1'b0, n_steps, 26'h0}) -
                                $signed(49'(fw * rational_step_divider_reg)); // [RULE2]
    wire signed [17:0] rsum = res_reg + r_full[17:0];
    wire up = rational && rsum >= rdiv_s;
    wire dn = rational && rsum < 18'sd0;
    wire [31:0] inc = fw + {{31{dn}}, up | dn}; // [RULE1] [RULE2]
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
        acc_reg <= 32'h0;
        res_reg <= 18'sd0;
      end else if (sync_pulse) begin
        acc_reg <= 32'h0; // [RULE15] [RULE13]
        res_reg <= 18'sd0;
      end else begin
        acc_reg <= acc_reg + inc;
        res_reg <= !rational ? 18'sd0 : up ? rsum - rdiv_s : dn ? rsum + rdiv_s : rsum;
      end
    end
    assign osc_phase_w[o] = acc_reg + {pw, 16'h0000}; // [RULE7]
  end

  // Two paths: mixer, five halving stages, output word
  wire bypass = !(dec_mode_reg >= 3'h1 && dec_mode_reg <= 3'h4);

  genvar p, s;
  for (p = 0; p < 2; p++) begin : g_path
    logic mix_v_reg;
    logic signed [DW-1:0] mix_i_reg;
    logic signed [DW-1:0] mix_q_reg;
    ddcns_word_t out_reg;
    wire [NS:0] sv;
    wire signed [DW-1:0] si [0:NS];
    wire signed [DW-1:0] sq [0:NS];
    wire [1:0] sel = p == 0 ? sel_a_reg : sel_b_reg;
    wire [31:0] ph = osc_phase_w[{p == 1, sel}];
    wire signed [SAMPLE_W-1:0] x = sample_i[p];
    wire signed [SAMPLE_W+11:0] prod_i = x * cos_lut(ph[31:27]);
    wire signed [SAMPLE_W+11:0] prod_q = -(x * cos_lut(ph[31:27] - 5'd8));

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
        mix_v_reg <= 1'b0;
        mix_i_reg <= '0;
        mix_q_reg <= '0;
      end else begin
        mix_v_reg <= !bypass;
        mix_i_reg <= DW'(prod_i >>> `DDCNS_MIX_SHIFT); // [RULE19]
        mix_q_reg <= DW'(prod_q >>> `DDCNS_MIX_SHIFT);
      end
    end
    assign sv[0] = mix_v_reg;
    assign si[0] = mix_i_reg;
    assign sq[0] = mix_q_reg;

    for (s = 0; s < NS; s++) begin : g_stage
      logic signed [DW-1:0] ti_reg [0:5];
      logic signed [DW-1:0] tq_reg [0:5];
      logic ph_reg;
      logic v_reg;
      logic signed [DW-1:0] i_reg;
      logic signed [DW-1:0] q_reg;
      wire used = stage_used(dec_mode_reg, s); // [RULE22]
      always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
          for (int t = 0; t < 6; t++) begin
            ti_reg[t] <= '0;
            tq_reg[t] <= '0;
          end
          ph_reg <= 1'b0;
          v_reg <= 1'b0;
          i_reg <= '0;
          q_reg <= '0;
        end else if (!used) begin
          // Unused stages pass samples on one clock later
          ph_reg <= 1'b0;
          v_reg <= sv[s];
          i_reg <= si[s];
          q_reg <= sq[s];
        end else begin
          v_reg <= sv[s] & ph_reg; // [RULE21]
          if (sv[s]) begin
            ti_reg[0] <= si[s];
            tq_reg[0] <= sq[s];
            for (int t = 1; t < 6; t++) begin
              ti_reg[t] <= ti_reg[t-1];
              tq_reg[t] <= tq_reg[t-1];
            end
            ph_reg <= ~ph_reg;
            i_reg <= hb_fir(si[s], ti_reg[1], ti_reg[2], ti_reg[3], ti_reg[5]); // [RULE20] [RULE23]
            q_reg <= hb_fir(sq[s], tq_reg[1], tq_reg[2], tq_reg[3], tq_reg[5]);
          end
        end
      end
      assign sv[s+1] = v_reg;
      assign si[s+1] = i_reg;
      assign sq[s+1] = q_reg;
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
        out_reg <= '0;
      end else if (bypass) begin
        out_reg.valid <= 1'b1; // [RULE18]
        out_reg.i_word <= {x, {(DW-SAMPLE_W){1'b0}}, ovr_i[p][0]};
        out_reg.q_word <= {15'h0000, ovr_i[p][1]};
      end else begin
        out_reg.valid <= sv[NS];
        out_reg.i_word <= {si[NS], ovr_i[p][0]}; // [RULE24]
        out_reg.q_word <= {sq[NS], ovr_i[p][1]};
      end
    end
    assign ddc_out_o[p] = out_reg;
  end

  assign apb_rsp_o = '{pready: pready_reg, prdata: prdata_reg, pslverr: pslverr_reg};
  assign serial_link_enable_o = link_en_reg;
  assign nco_sync_o = nco_sync_reg;
endmodule

// ### ddcns_core_tb.sv
// Self-checking bench for the down-converter core
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module ddcns_core_tb;
  import ddcns_pkg::*;
  logic clk;
  logic resetn = 1'b0;
  ddcns_apb_req_t req = '0;
  ddcns_apb_rsp_t rsp;
  logic sync_n;
  logic sysref = 1'b0;
  logic [1:0][11:0] smp = '0;
  logic [1:0][1:0] ovr = '0;
  logic link_en;
  logic nsync;
  ddcns_word_t [1:0] dout;
  logic go = 1'b0;
  logic [7:0] hold = 8'h08;
  logic [31:0] rd, v;
  logic er;
  logic [31:0] q[$];
  int miscompares = 0;
  int total_checks = 0;
  int syncs = 0;
  int exp_cnt = 0;
  int n0;
  ddcns_core dut (.clk_sys_i(clk), .resetn_i(resetn), .apb_req_i(req), .apb_rsp_o(rsp),
    .link_sync_n_i(sync_n), .sysref_i(sysref), .sample_i(smp), .ovr_i(ovr),
    .serial_link_enable_o(link_en), .nco_sync_o(nsync), .ddc_out_o(dout));
  ddcns_link_rx rx (.clk_sys_i(clk), .resetn_i(resetn), .go_i(go), .hold_i(hold),
    .link_sync_n_o(sync_n));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    smp <= 24'($urandom);
    ovr <= 4'($urandom);
    if (nsync === 1'b1) syncs++;
  end
  task automatic report_and_stop;
    $display("checks=%0d miscompares=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Holds the request until pready is seen at an edge, then releases
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 16);
    if (n >= 16) miscompares++;
    rd = rsp.prdata;
    er = rsp.pslverr;
    req <= '0;
    @(posedge clk);
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    report_and_stop();
  end
  initial begin
    void'($urandom(32'h1AAE37E1));
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    for (int k = 0; k < 3; k++) begin
      apb(1'b0, 12'(4 * k), 32'h0);
      `CHK(rd, k == 2 ? 32'h0000_0001 : 32'h0)
    end
    for (int k = 0; k < 8; k++) begin
      v = $urandom;
      apb(1'b1, 12'h020 + 12'(4 * k), v);
      apb(1'b0, 12'h020 + 12'(4 * k), 32'h0);
      `CHK(rd, v)
      apb(1'b1, 12'h040 + 12'(4 * k), v);
      apb(1'b0, 12'h040 + 12'(4 * k), 32'h0);
      `CHK(rd, {16'h0000, v[15:0]})
    end
    apb(1'b1, 12'h004, 32'h0000_0780);
    apb(1'b0, 12'h004, 32'h0);
    `CHK(rd, 32'h0000_0780)
    apb(1'b1, 12'h008, 32'hFFFF_FFFF);
    apb(1'b0, 12'h008, 32'h0);
    `CHK(rd, 32'h0000_0001)
    apb(1'b0, 12'h00C, 32'h0);
    `CHK({er, rd}, {1'b1, 32'h0})
    apb(1'b0, 12'h021, 32'h0);
    `CHK(er, 1'b1)
    $display("test registers done");
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      if (i > 0) `CHK({dout[0].i_word, dout[1].q_word}, q.pop_front())
      `CHK({dout[0].valid, dout[1].valid}, 2'b11)
      q.push_back({smp[0], 3'h0, ovr[0][0], 15'h0000, ovr[1][1]});
    end
    $display("test bypass done");
    for (int d = 1; d <= 5; d++) begin
      apb(1'b1, 12'h000, 32'(d) << 4);
      repeat (300) @(posedge clk);
      n0 = 0;
      repeat (256) begin
        @(posedge clk);
        if (dout[0].valid === 1'b1) n0++;
      end
      `CHK(n0, d == 5 ? 256 : 256 >> (d + 1))
    end
    $display("test decimation done");
    apb(1'b1, 12'h000, 32'h0000_0004);
    apb(1'b0, 12'h000, 32'h0);
    `CHK(rd[2], 1'b1)
    for (int i = 0; i < 2; i++) begin
      n0 = syncs;
      sysref <= 1'b1;
      // The pin filter drops pulses shorter than two clocks
      repeat (2 + $urandom % 7) @(posedge clk);
      sysref <= 1'b0;
      repeat (20) @(posedge clk);
      exp_cnt += 1 - i;
      `CHK(syncs, n0 + 1 - i)
    end
    apb(1'b0, 12'h000, 32'h0);
    `CHK(rd[2], 1'b0)
    $display("test sysref done");
    for (int e = 0; e < 3; e++) begin
      n0 = syncs;
      apb(1'b1, 12'h000, e == 2 ? 32'h1 : 32'h2 | 32'(e) << 3);
      apb(1'b1, 12'h000, e == 2 ? 32'h1 : 32'h3 | 32'(e) << 3);
      `CHK(link_en, 1'b1)
      hold <= 8'(4 + $urandom % 40);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (60) @(posedge clk);
      exp_cnt += int'(e < 2);
      `CHK(syncs, n0 + int'(e < 2))
    end
    apb(1'b0, 12'h008, 32'h0);
    `CHK(rd[15:8], 8'(exp_cnt))
    $display("test link sync done");
    report_and_stop();
  end
endmodule

// ### ddcns_link_rx.sv
// Serial link receiver model driving the active-low link sync pin
`timescale 1ns/1ps
module ddcns_link_rx (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic go_i,
  input wire logic [7:0] hold_i,
  output logic link_sync_n_o
);
  logic [7:0] cnt_reg;
  // Hold time sets prompt or slow release; zero is not allowed
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      link_sync_n_o <= 1'b1;
      cnt_reg <= 8'h00;
    end else if (go_i && cnt_reg == 8'h00) begin
      link_sync_n_o <= 1'b0;
      cnt_reg <= hold_i;
    end else if (cnt_reg != 8'h00) begin
      cnt_reg <= cnt_reg - 8'h01;
      link_sync_n_o <= cnt_reg == 8'h01;
    end
  end
endmodule

// ### ddcns_monitor.sv
// Port checker for the down-converter core, bound to every instance
`timescale 1ns/1ps
module ddcns_monitor #(
  parameter int SAMPLE_W = 12
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire ddcns_pkg::ddcns_apb_req_t apb_req_i,
  input wire ddcns_pkg::ddcns_apb_rsp_t apb_rsp_o,
  input wire logic link_sync_n_i,
  input wire logic sysref_i,
  input wire logic [1:0][SAMPLE_W-1:0] sample_i,
  input wire logic [1:0][1:0] ovr_i,
  input wire logic serial_link_enable_o,
  input wire logic nco_sync_o,
  input wire ddcns_pkg::ddcns_word_t [1:0] ddc_out_o
);
  import ddcns_pkg::*;
  logic [2:0] dec_reg;
  logic arm_reg;
  logic [7:0] mcnt_reg;
  logic [7:0] gap_reg;
  wire logic acc_done = apb_req_i.psel && apb_req_i.penable && apb_rsp_o.pready;
  wire logic wr_ctrl = acc_done && apb_req_i.pwrite && apb_req_i.paddr == 12'h000;
  // Codes 5..7 fall back to bypass
  wire logic byp = dec_reg == 3'h0 || dec_reg > 3'h4;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dec_reg <= 3'h0;
      arm_reg <= 1'b0;
      mcnt_reg <= 8'h00;
      gap_reg <= 8'h00;
    end else begin
      dec_reg <= wr_ctrl ? apb_req_i.pwdata[6:4] : dec_reg;
      // A fresh arm wins over a sync in the same cycle
      arm_reg <= (wr_ctrl && apb_req_i.pwdata[2]) || (arm_reg && !nco_sync_o);
      mcnt_reg <= wr_ctrl ? 8'h00 : mcnt_reg + 8'(mcnt_reg != 8'hFF);
      gap_reg <= ddc_out_o[0].valid ? 8'h01 : gap_reg + 8'(gap_reg != 8'hFF);
    end
  end
  AST_APB_WAIT: assert property (apb_req_i.psel && $rose(apb_req_i.penable)
    |-> !apb_rsp_o.pready ##1 apb_rsp_o.pready) else $error("pready late or early");
  AST_APB_ERR: assert property (apb_rsp_o.pready && (apb_req_i.paddr == 12'h00C
    || apb_req_i.paddr[1:0] != 2'h0) |-> apb_rsp_o.pslverr && apb_rsp_o.prdata == 32'h0)
    else $error("bad address not refused");
  AST_LINK_EN: assert property (
    wr_ctrl |=> serial_link_enable_o == $past(apb_req_i.pwdata[0]))
    else $error("link enable not following control write");
  AST_SYSREF_FIRE: assert property (
    $rose(sysref_i) && arm_reg |-> ##[3:10] nco_sync_o) else $error("armed edge missed");
  AST_NO_SPURIOUS: assert property (
    nco_sync_o |-> arm_reg || serial_link_enable_o) else $error("sync without source");
  AST_ONE_SHOT: assert property (
    nco_sync_o |=> !nco_sync_o [*4]) else $error("repeated oscillator reset");
  AST_BYP_VALID: assert property (
    byp && mcnt_reg > 8'h02 |-> ddc_out_o[0].valid && ddc_out_o[1].valid)
    else $error("bypass output not every clock");
  AST_BYP_DATA: assert property (
    byp && mcnt_reg > 8'h02 |-> ddc_out_o[0].i_word == {$past(sample_i[0]), 3'h0,
    $past(ovr_i[0][0])} && ddc_out_o[1].q_word == {15'h0000, $past(ovr_i[1][1])})
    else $error("bypass word wrong");
  AST_DEC_RATE: assert property (
    ddc_out_o[0].valid && !byp && mcnt_reg == 8'hFF |-> gap_reg == (8'h02 << dec_reg))
    else $error("decimated output spacing wrong");
  COV_SYSREF: cover property ($rose(sysref_i) && arm_reg);
  COV_LINK: cover property ($rose(link_sync_n_i) && serial_link_enable_o);
  COV_DEC32: cover property (ddc_out_o[0].valid && dec_reg == 3'h4 && mcnt_reg == 8'hFF);
endmodule
bind ddcns_core ddcns_monitor #(.SAMPLE_W(SAMPLE_W)) u_monitor (
  .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .apb_req_i(apb_req_i),
  .apb_rsp_o(apb_rsp_o), .link_sync_n_i(link_sync_n_i), .sysref_i(sysref_i),
  .sample_i(sample_i), .ovr_i(ovr_i), .serial_link_enable_o(serial_link_enable_o),
  .nco_sync_o(nco_sync_o), .ddc_out_o(ddc_out_o)
);

// ### ddcns_pkg.sv
// Types shared by the down-converter core and its users
package ddcns_pkg;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } ddcns_apb_req_t;
  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } ddcns_apb_rsp_t;
  typedef struct packed {
    logic valid;
    logic [15:0] i_word;
    logic [15:0] q_word;
  } ddcns_word_t;
  typedef enum logic [2:0] {
    DDCNS_LS_IDLE = 3'b001,
    DDCNS_LS_WAIT = 3'b010,
    DDCNS_LS_ARMED = 3'b100
  } ddcns_link_state_t;
endpackage
